// ==== verilog/lcd_parallel_master_port.sv ====
// Contract
// - Display pins driven only while iface_enable set; otherwise returned to port use.
// - After reset every display signal is held high.
// - bus_style_select picks 6800 or 8080 access convention.
// - Pin roles follow style; chip select and data bus same in both.
// - cycle_type_select_bit picks normalized or special waveforms for both styles.
// - One 2-bit setting gives address setup and hold, 1 to 4 clocks.
// - Strobe width is a 4-bit setting, 1 to 16 clocks.
// - Sleep wait of 1 to 4 clocks between consecutive accesses.
// - Full cycle is setup plus strobe plus hold plus sleep, plus a strobe-width gap before sleep with inactive_width_match.
// - inactive_width_match keeps strobe inactive for the strobe width.
// - Optional automatic busy check after every read or write access.
// - Busy status reads drive register select pin to status_addr_level.
// - Busy engine rereads status until all masked bits deasserted.
// - busy_polarity_low set means masked bits busy while low.
// - All-zero busy mask means no busy check.
// - Busy flag set at cycle start, cleared after final sleep wait.
// - Writing the data register starts one write cycle while enabled.
// - Setting read_command starts one read cycle while enabled.
// - Captured byte readable from data register; each read restarts a read.
// - read_command clears itself as soon as its read cycle starts.
// - With busy checking, sleep wait sits between access and busy check.
`timescale 1ns/10ps
module lcd_parallel_master_port (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [lcd_port_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic                                   port_owned,
  output logic                                   write_or_rw_pin,
  output logic                                   read_or_enable_pin,
  output logic                                   reg_select_pin,
  output logic                                   chip_select_pin,
  output logic      [7:0]                        display_data_out,
  output logic                                   display_data_oe_n,
  input  wire logic [7:0]                        display_data_bus
);

  lcd_port_pkg::ctrl_a_t    ctrl_a_reg;
  lcd_port_pkg::ctrl_b_t    ctrl_b_reg;
  logic [7:0]               busy_mask_reg;
  logic [7:0]               wr_data_reg;
  logic [7:0]               rd_data_reg;
  logic                     port_busy_flag;
  lcd_port_pkg::cyc_state_t state_reg;
  lcd_port_pkg::cyc_state_t state_next;
  logic [lcd_port_pkg::CNT_W-1:0] cnt_reg;
  logic [lcd_port_pkg::CNT_W-1:0] cnt_next;
  logic                     op_write_reg;
  logic                     op_status_reg;
  logic                     op_rs_reg;
  logic                     status_ready_reg;
  logic                     apb_access;
  logic                     apb_wr;
  logic                     apb_rd;
  logic                     unmapped;
  logic                     start_write;
  logic                     start_read;
  logic                     can_start;
  logic                     check_on;
  logic                     last_cnt;
  logic                     seq_done;
  logic                     read_done;
  logic                     strobe_end;
  logic                     status_ready;
  logic [7:0]               busy_bits;
  logic [lcd_port_pkg::CNT_W-1:0] ash_cnt;
  logic [lcd_port_pkg::CNT_W-1:0] acc_cnt;
  logic [lcd_port_pkg::CNT_W-1:0] slw_cnt;
  lcd_port_pkg::disp_pins_t pins_next;
  logic                     drive_next;

  // Bus decode
  assign apb_access = psel && penable && pready;
  assign apb_wr     = apb_access && pwrite;
  assign apb_rd     = apb_access && !pwrite;
  assign unmapped   = (paddr != lcd_port_pkg::CTRL_A_OFS) && (paddr != lcd_port_pkg::CTRL_B_OFS)
                   && (paddr != lcd_port_pkg::STATUS_OFS) && (paddr != lcd_port_pkg::MASK_OFS)
                   && (paddr != lcd_port_pkg::DATA_OFS);

  assign ash_cnt = lcd_port_pkg::CNT_W'(ctrl_a_reg.addr_setup_hold_len);
  assign acc_cnt = ctrl_a_reg.strobe_width_len;
  assign slw_cnt = lcd_port_pkg::CNT_W'(ctrl_b_reg.sleep_wait_len);
  assign last_cnt = (cnt_reg == '0);

  assign check_on = |busy_mask_reg;

  assign busy_bits = ctrl_a_reg.busy_polarity_low ? (~display_data_bus & busy_mask_reg)
                                                  : (display_data_bus & busy_mask_reg);
  assign status_ready = ~|busy_bits;

  assign can_start = ctrl_b_reg.iface_enable && (state_reg == lcd_port_pkg::ST_IDLE)
                  && !port_busy_flag;
  assign start_write = can_start && apb_wr && (paddr == lcd_port_pkg::DATA_OFS);
  // read on command or data read
  assign start_read  = can_start && !start_write
                    && (ctrl_b_reg.read_command
                        || (apb_rd && (paddr == lcd_port_pkg::DATA_OFS)));

  assign strobe_end = (state_reg == lcd_port_pkg::ST_STROBE) && last_cnt;
  assign seq_done   = (state_reg == lcd_port_pkg::ST_SLEEP) && last_cnt
                   && (!check_on || (op_status_reg && status_ready_reg));
  assign read_done  = seq_done && !op_write_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      lcd_port_pkg::ST_IDLE: begin
        if (start_write || start_read) begin
          state_next = lcd_port_pkg::ST_SETUP;
          cnt_next   = ash_cnt;
        end
      end
      lcd_port_pkg::ST_SETUP: begin
        if (last_cnt) begin
          state_next = lcd_port_pkg::ST_STROBE;
          cnt_next   = acc_cnt;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      lcd_port_pkg::ST_STROBE: begin
        if (last_cnt) begin
          state_next = lcd_port_pkg::ST_HOLD;
          cnt_next   = ash_cnt;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      lcd_port_pkg::ST_HOLD: begin
        if (!last_cnt) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (ctrl_b_reg.inactive_width_match) begin
          state_next = lcd_port_pkg::ST_GAP;
          cnt_next   = acc_cnt;
        end else begin
          state_next = lcd_port_pkg::ST_SLEEP;
          cnt_next   = slw_cnt;
        end
      end
      lcd_port_pkg::ST_GAP: begin
        if (last_cnt) begin
          state_next = lcd_port_pkg::ST_SLEEP;
          cnt_next   = slw_cnt;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      lcd_port_pkg::ST_SLEEP: begin
        if (!last_cnt) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (seq_done) begin
          state_next = lcd_port_pkg::ST_IDLE;
        end else begin
          state_next = lcd_port_pkg::ST_SETUP;
          cnt_next   = ash_cnt;
        end
      end
      default: begin
        state_next = lcd_port_pkg::ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lcd_port_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else if (!ctrl_b_reg.iface_enable) begin
      state_reg <= lcd_port_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Operation kind for the current cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_write_reg  <= 1'b0;
      op_status_reg <= 1'b0;
      op_rs_reg     <= 1'b0;
    end else if (state_reg == lcd_port_pkg::ST_IDLE) begin
      op_write_reg  <= start_write;
      op_status_reg <= 1'b0;
      op_rs_reg     <= ctrl_b_reg.reg_select_level;
    end else if ((state_reg == lcd_port_pkg::ST_SLEEP) && last_cnt && check_on) begin
      op_write_reg  <= 1'b0;
      op_status_reg <= 1'b1;
      op_rs_reg     <= ctrl_b_reg.status_addr_level;
    end
  end

  // Capture read byte and status verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_reg      <= lcd_port_pkg::DATA_RST;
      status_ready_reg <= 1'b0;
    end else if (strobe_end && !op_write_reg) begin
      if (op_status_reg) begin
        status_ready_reg <= status_ready;
      end else begin
        rd_data_reg      <= display_data_bus;
        status_ready_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_busy_flag <= 1'b0;
    end else if (start_write || start_read) begin
      port_busy_flag <= 1'b1;
    end else if (seq_done || !ctrl_b_reg.iface_enable) begin
      port_busy_flag <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg    <= lcd_port_pkg::CTRL_A_RST;
      ctrl_b_reg    <= lcd_port_pkg::CTRL_B_RST;
      busy_mask_reg <= lcd_port_pkg::MASK_RST;
      wr_data_reg   <= lcd_port_pkg::DATA_RST;
    end else begin
      if (apb_wr && (paddr == lcd_port_pkg::CTRL_A_OFS)) begin
        ctrl_a_reg <= pwdata[7:0];
      end
      if (apb_wr && (paddr == lcd_port_pkg::CTRL_B_OFS)) begin
        ctrl_b_reg <= pwdata[7:0];
      end else if (start_read || read_done) begin
        ctrl_b_reg.read_command <= 1'b0;
      end
      if (apb_wr && (paddr == lcd_port_pkg::MASK_OFS)) begin
        busy_mask_reg <= pwdata[7:0];
      end
      if (start_write) begin
        wr_data_reg <= pwdata[7:0];
      end
    end
  end

  // Bus slave answer with one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && unmapped;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          lcd_port_pkg::CTRL_A_OFS: prdata <= {24'h000000, ctrl_a_reg};
          lcd_port_pkg::CTRL_B_OFS: prdata <= {24'h000000, ctrl_b_reg};
          lcd_port_pkg::STATUS_OFS: prdata <= {31'h00000000, port_busy_flag};
          lcd_port_pkg::MASK_OFS:   prdata <= {24'h000000, busy_mask_reg};
          lcd_port_pkg::DATA_OFS:   prdata <= {24'h000000, rd_data_reg};
          default:                  prdata <= '0;
        endcase
      end
    end
  end

  always_comb begin
    pins_next  = '1;
    drive_next = 1'b0;
    if (ctrl_a_reg.bus_style_select == lcd_port_pkg::STYLE_6800) begin
      pins_next.read_or_enable_pin = 1'b0;
    end
    if ((state_reg == lcd_port_pkg::ST_SETUP) || (state_reg == lcd_port_pkg::ST_STROBE)
        || (state_reg == lcd_port_pkg::ST_HOLD)) begin
      pins_next.reg_select_pin  = op_rs_reg;
      pins_next.chip_select_pin = ctrl_b_reg.cycle_type_select_bit
                                  ? (state_reg != lcd_port_pkg::ST_STROBE) : 1'b0;
      drive_next                = op_write_reg;
      if (ctrl_a_reg.bus_style_select == lcd_port_pkg::STYLE_6800) begin
        pins_next.write_or_rw_pin    = !op_write_reg;
        pins_next.read_or_enable_pin = (state_reg == lcd_port_pkg::ST_STROBE);
      end else if (state_reg == lcd_port_pkg::ST_STROBE) begin
        pins_next.write_or_rw_pin    = !op_write_reg;
        pins_next.read_or_enable_pin = op_write_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_owned         <= 1'b0;
      write_or_rw_pin    <= 1'b1;
      read_or_enable_pin <= 1'b1;
      reg_select_pin     <= 1'b1;
      chip_select_pin    <= 1'b1;
      display_data_out   <= 8'hff;
      display_data_oe_n  <= 1'b1;
    end else if (!ctrl_b_reg.iface_enable) begin
      port_owned         <= 1'b0;
      write_or_rw_pin    <= 1'b1;
      read_or_enable_pin <= 1'b1;
      reg_select_pin     <= 1'b1;
      chip_select_pin    <= 1'b1;
      display_data_out   <= 8'hff;
      display_data_oe_n  <= 1'b1;
    end else begin
      port_owned         <= 1'b1;
      write_or_rw_pin    <= pins_next.write_or_rw_pin;
      read_or_enable_pin <= pins_next.read_or_enable_pin;
      reg_select_pin     <= pins_next.reg_select_pin;
      chip_select_pin    <= pins_next.chip_select_pin;
      display_data_out   <= wr_data_reg;
      display_data_oe_n  <= !drive_next;
    end
  end

endmodule

// ==== verilog/lcd_port_pkg.sv ====
package lcd_port_pkg;

  localparam int unsigned ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_A_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] CTRL_B_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 5'h0c;
  localparam logic [ADDR_W-1:0] DATA_OFS   = 5'h10;

  // Field widths
  localparam int unsigned SETUP_HOLD_W = 2;
  localparam int unsigned STROBE_W     = 4;
  localparam int unsigned SLEEP_W      = 2;
  localparam int unsigned CNT_W        = 4;

  // Reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;

  // Bus style encoding of bus_style_select
  localparam logic STYLE_8080 = 1'b0;
  localparam logic STYLE_6800 = 1'b1;

  typedef struct packed {
    logic                    busy_polarity_low;
    logic                    bus_style_select;
    logic [SETUP_HOLD_W-1:0] addr_setup_hold_len;
    logic [STROBE_W-1:0]     strobe_width_len;
  } ctrl_a_t;

  typedef struct packed {
    logic [SLEEP_W-1:0] sleep_wait_len;
    logic               status_addr_level;
    logic               inactive_width_match;
    logic               cycle_type_select_bit;
    logic               iface_enable;
    logic               read_command;
    logic               reg_select_level;
  } ctrl_b_t;

  typedef struct packed {
    logic write_or_rw_pin;
    logic read_or_enable_pin;
    logic reg_select_pin;
    logic chip_select_pin;
  } disp_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_GAP    = 3'b110,
    ST_SLEEP  = 3'b111
  } cyc_state_t;

endpackage

// ==== sim/lcd_port_sva.sv ====
`timescale 1ns/10ps
module lcd_port_sva (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [lcd_port_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic                            pready,
  input wire logic                            port_owned,
  input wire logic                            write_or_rw_pin,
  input wire logic                            read_or_enable_pin,
  input wire logic                            reg_select_pin,
  input wire logic                            chip_select_pin,
  input wire logic                            display_data_oe_n
);
  logic       s68;
  logic       spec;
  logic       owned_d;
  logic       strb;
  logic [1:0] sh;
  logic [3:0] sw;
  logic [4:0] wcnt;
  logic [4:0] pcnt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Snoop timing fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s68 <= 1'h0;
      spec <= 1'h0;
      sh <= 2'h0;
      sw <= 4'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == lcd_port_pkg::CTRL_A_OFS) begin
        s68 <= pwdata[6];
        sh <= pwdata[5:4];
        sw <= pwdata[3:0];
      end
      if (paddr == lcd_port_pkg::CTRL_B_OFS) spec <= pwdata[3];
    end
  end
  always_comb strb = owned_d && port_owned &&
                     (s68 ? read_or_enable_pin : (!write_or_rw_pin || !read_or_enable_pin));
  // Phase counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owned_d <= 1'h0;
      wcnt <= 5'h00;
      pcnt <= 5'h00;
    end else begin
      owned_d <= port_owned;
      wcnt <= strb ? wcnt + 5'h01 : 5'h00;
      pcnt <= chip_select_pin ? 5'h00 : (strb ? pcnt : pcnt + 5'h01);
    end
  end
  pins_idle_a: assert property (!port_owned |->
    {write_or_rw_pin, read_or_enable_pin, reg_select_pin, chip_select_pin} == 4'hf)
    else $error("pins not high while released");
  reset_high_a: assert property ($rose(presetn) |-> chip_select_pin && write_or_rw_pin &&
    read_or_enable_pin && reg_select_pin && display_data_oe_n)
    else $error("pins not high after reset");
  cs_strobe_a: assert property (strb |-> !chip_select_pin)
    else $error("strobe without chip select");
  one_strobe_a: assert property (port_owned && !s68 |-> write_or_rw_pin || read_or_enable_pin)
    else $error("both strobes active");
  rw_stable_a: assert property (strb && s68 && $past(strb) |-> $stable(write_or_rw_pin))
    else $error("direction moved during enable");
  oe_write_a: assert property (port_owned && s68 && !display_data_oe_n |-> !write_or_rw_pin)
    else $error("data driven outside write");
  setup_len_a: assert property ($rose(strb) && !spec |-> pcnt == {3'h0, sh} + 5'h01)
    else $error("setup length wrong");
  strobe_len_a: assert property ($fell(strb) |-> wcnt == {1'h0, sw} + 5'h01)
    else $error("strobe length wrong");
endmodule
bind lcd_parallel_master_port lcd_port_sva lcd_port_sva_i (
  .pclk               (pclk),
  .presetn            (presetn),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .pready             (pready),
  .port_owned         (port_owned),
  .write_or_rw_pin    (write_or_rw_pin),
  .read_or_enable_pin (read_or_enable_pin),
  .reg_select_pin     (reg_select_pin),
  .chip_select_pin    (chip_select_pin),
  .display_data_oe_n  (display_data_oe_n)
);

// ==== sim/lcd_ctrl_model.sv ====
`timescale 1ns/10ps
module lcd_ctrl_model (
  input  wire logic       pclk,
  input  wire logic       s68,
  input  wire logic       st_lvl,
  input  wire logic [7:0] busy_byte,
  input  wire logic [7:0] ready_byte,
  input  wire logic [7:0] data_byte,
  input  wire logic [7:0] limit,
  input  wire logic       write_or_rw_pin,
  input  wire logic       read_or_enable_pin,
  input  wire logic       reg_select_pin,
  input  wire logic       chip_select_pin,
  output logic      [7:0] drive,
  output logic      [7:0] st_cnt
);
  logic       rd_act;
  logic       rd_d = 1'h0;
  logic [7:0] last = 8'h00;
  logic [7:0] polls = 8'h00;
  assign rd_act = !chip_select_pin &&
                  (s68 ? (read_or_enable_pin && write_or_rw_pin) : !read_or_enable_pin);
  // Released bus toggles
  assign drive = !rd_act ? ~last : (reg_select_pin != st_lvl) ? data_byte :
                 (st_cnt < limit) ? busy_byte : ready_byte;
  assign st_cnt = polls;
  always @(posedge pclk) begin
    rd_d <= rd_act;
    last <= drive;
    if (rd_d && !rd_act && reg_select_pin == st_lvl) polls <= polls + 8'h01;
  end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [4:0]  paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, port_owned, display_data_oe_n;
  logic        write_or_rw_pin, read_or_enable_pin, reg_select_pin, chip_select_pin;
  logic [7:0]  display_data_out, display_data_bus, drive, st_cnt, c0, db, rw;
  logic [7:0]  limit = 8'h00;
  logic [7:0]  busy_byte = 8'h80;
  logic [7:0]  ready_byte = 8'h7f;
  logic [7:0]  data_byte = 8'h3c;
  logic        s68 = 1'h0;
  logic        st_lvl = 1'h1;
  int          miscompares = 0;
  int          checks = 0;
  int          lo, sb, hi;
  wire         strb = s68 ? read_or_enable_pin : (!write_or_rw_pin || !read_or_enable_pin);
  assign display_data_bus = display_data_oe_n ? drive : display_data_out;
  always #2.5 pclk = ~pclk;
  lcd_parallel_master_port lcd_parallel_master_port_i (.*);
  lcd_ctrl_model lcd_ctrl_model_i (.*);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic idle();
    do apb(1'h0, lcd_port_pkg::STATUS_OFS, 32'h0); while (rd[0] !== 1'h0);
  endtask
  task automatic shape();
    lo = 0;
    sb = 0;
    while (chip_select_pin !== 1'h0) @(negedge pclk);
    while (chip_select_pin === 1'h0) begin
      lo++;
      if (strb) begin
        sb++;
        db = display_data_bus;
        rw = {7'h0, write_or_rw_pin};
      end
      @(negedge pclk);
    end
  endtask
  task automatic gap();
    hi = 0;
    while (chip_select_pin === 1'h1 && hi < 16) begin
      hi++;
      @(negedge pclk);
    end
  endtask
  task automatic t_reset();
    check("pins", {28'h0, write_or_rw_pin, read_or_enable_pin, reg_select_pin, chip_select_pin}, 32'hf);
    check("owned", {31'h0, port_owned}, 32'h0);
    apb(1'h1, 5'h14, 32'h1);
    check("slverr", {31'h0, er}, 32'h1);
    apb(1'h0, lcd_port_pkg::STATUS_OFS, 32'h0);
    check("busy", rd, 32'h0);
  endtask
  task automatic t_write();
    apb(1'h1, lcd_port_pkg::CTRL_A_OFS, 32'h12);
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, 32'h44);
    apb(1'h1, lcd_port_pkg::DATA_OFS, 32'ha5);
    fork
      shape();
      apb(1'h0, lcd_port_pkg::STATUS_OFS, 32'h0);
    join
    check("busy", rd, 32'h1);
    check("cs low", lo, 32'h7);
    check("strobe", sb, 32'h3);
    check("byte", {24'h0, db}, 32'ha5);
    idle();
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, 32'h4c);
    apb(1'h1, lcd_port_pkg::DATA_OFS, 32'h11);
    shape();
    check("special cs", lo, 32'h3);
    idle();
  endtask
  task automatic t_off();
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, 32'h0);
    repeat (2) @(negedge pclk);
    check("owned", {31'h0, port_owned}, 32'h0);
    apb(1'h1, lcd_port_pkg::DATA_OFS, 32'h5a);
    apb(1'h0, lcd_port_pkg::STATUS_OFS, 32'h0);
    check("busy", rd, 32'h0);
  endtask
  task automatic t_read();
    s68 <= 1'h1;
    apb(1'h1, lcd_port_pkg::CTRL_A_OFS, 32'h51);
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, 32'h46);
    shape();
    check("cs low", lo, 32'h6);
    check("enable", sb, 32'h2);
    check("byte", {24'h0, db}, 32'h3c);
    check("rw", {24'h0, rw}, 32'h1);
    idle();
    apb(1'h0, lcd_port_pkg::CTRL_B_OFS, 32'h0);
    check("cmd", rd, 32'h44);
    fork
      shape();
      apb(1'h0, lcd_port_pkg::DATA_OFS, 32'h0);
    join
    check("data", rd, 32'h3c);
    check("again", lo, 32'h6);
    idle();
    apb(1'h1, lcd_port_pkg::DATA_OFS, 32'h96);
    shape();
    check("byte", {24'h0, db}, 32'h96);
    check("rw", {24'h0, rw}, 32'h0);
    idle();
  endtask
  task automatic t_busy(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] m);
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, 32'h0);
    s68 <= 1'h0;
    busy_byte <= ca[7] ? 8'h7f : 8'h80;
    ready_byte <= ca[7] ? 8'h80 : 8'h7f;
    apb(1'h1, lcd_port_pkg::CTRL_A_OFS, {24'h0, ca});
    apb(1'h1, lcd_port_pkg::MASK_OFS, {24'h0, m});
    apb(1'h1, lcd_port_pkg::CTRL_B_OFS, {24'h0, cb});
    limit <= st_cnt + 8'h02;
    c0 = st_cnt;
    apb(1'h1, lcd_port_pkg::DATA_OFS, 32'h5a);
    shape();
    gap();
    idle();
  endtask
  task automatic t_poll();
    t_busy(8'h12, 8'h74, 8'h80);
    check("gap", hi, 32'h5);
    check("polls", {24'h0, st_cnt - c0}, 32'h3);
    t_busy(8'h92, 8'h64, 8'h80);
    check("gap", hi, 32'h2);
    check("polls", {24'h0, st_cnt - c0}, 32'h3);
    t_busy(8'h12, 8'h64, 8'h00);
    check("gap", hi, 32'h10);
    check("polls", {24'h0, st_cnt - c0}, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    t_reset();
    t_write();
    t_off();
    t_read();
    t_poll();
    print_verdict();
  end
  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule
